/* File: hdl/term_io_pkg.sv */
// Constants shared by the terminal input/output routing block
package term_io_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int DEB_TICK_NS      = 100000;
  localparam int DEB_TICK_CYC     = (DEB_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISC_TIME_NS     = 1000000;
  localparam int DISC_CYC         = DISC_TIME_NS / CLK_PERIOD_NS;

  // Register bus widths
  localparam int ADDR_W           = 4;
  localparam int DATA_W           = 16;

  // Register offsets
  localparam logic [3:0] CTRL_OFS        = 4'h0;
  localparam logic [3:0] IFACE_OFS       = 4'h1;
  localparam logic [3:0] DEB_TIME_OFS    = 4'h2;
  localparam logic [3:0] SEL0_OFS        = 4'h3;
  localparam logic [3:0] INV_OFS         = 4'h6;
  localparam logic [3:0] IN_STATUS_OFS   = 4'h7;
  localparam logic [3:0] SAFE_STATUS_OFS = 4'h8;
  localparam logic [3:0] IRQ_STATUS_OFS  = 4'h9;
  localparam logic [3:0] IRQ_MASK_OFS    = 4'ha;
  localparam logic [3:0] CMD_OFS         = 4'hb;
  localparam logic [3:0] WORD_ONE_OFS    = 4'hc;
  localparam logic [3:0] WORD_TWO_OFS    = 4'hd;

  // Control register fields
  localparam int CTRL_STO_EN_BIT  = 0;
  localparam int CTRL_AI_EN_LSB   = 1;
  // Safety status fields
  localparam int SAFE_ACTIVE_BIT  = 0;
  localparam int SAFE_FAULT_BIT   = 1;
  localparam int SAFE_CH0_BIT     = 2;
  localparam int SAFE_CH1_BIT     = 3;
  // Interrupt status fields
  localparam int IRQ_FAULT_BIT    = 0;
  localparam int IRQ_STO_BIT      = 1;
  localparam int IRQ_CHANGE_BIT   = 2;
  // Command fields
  localparam int CMD_ACK_BIT      = 0;

  // Reset values
  localparam logic [3:0] IFACE_RST       = 4'h0;
  localparam logic [7:0] DEB_TIME_RST    = 8'h00;
  localparam logic [5:0] SEL_RST         = 6'h00;
  localparam logic [2:0] IRQ_MASK_RST    = 3'h0;

  // Interface assignment that pairs the two safety channels
  localparam logic [3:0] IFACE_FAILSAFE  = 4'h2;

  // Output source select codes
  localparam logic [5:0] SEL_OFF         = 6'h00;
  localparam logic [5:0] SEL_W1_BASE     = 6'h01;
  localparam logic [5:0] SEL_W2_BASE     = 6'h11;
  localparam logic [5:0] SEL_W2_END      = 6'h21;

endpackage

/* File: hdl/input_filter.sv */
// Debounce filter for one terminal input
`timescale 1ns/100ps
module input_filter
  import term_io_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Filter control
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] limit,
  // Signal
  input  wire logic             raw,
  output logic                  level
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
  } filt_state_t;

  filt_state_t state_reg;
  filt_state_t state_next;

  // New level accepted once stable for limit ticks; limit 0 passes at once
  always_comb begin
    state_next = state_reg;
    if (raw == state_reg.level) begin
      state_next.cnt = '0;
    end else if (state_reg.cnt >= limit) begin
      state_next.level = raw;
      state_next.cnt   = '0;
    end else if (tick) begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
  end

  // Level resets low, which reads as a safety demand on the paired channels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;

endmodule

/* File: hdl/output_route.sv */
// Source selection and inversion for one binary output
`timescale 1ns/100ps
module output_route
  import term_io_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Status sources
  input  wire logic [15:0] word_one,
  input  wire logic [15:0] word_two,
  // Configuration
  input  wire logic [5:0]  sel,
  input  wire logic        invert,
  // Output
  output logic             drive
);

  typedef struct packed {
    logic drive;
  } route_state_t;

  route_state_t state_reg;
  route_state_t state_next;
  logic [3:0]   w1_idx;
  logic [3:0]   w2_idx;

  assign w1_idx = 4'(sel - SEL_W1_BASE);
  assign w2_idx = 4'(sel - SEL_W2_BASE);

  // Pick a status bit, then invert; unused codes stay off
  always_comb begin
    state_next = state_reg;
    if (sel == SEL_OFF) begin
      state_next.drive = 1'b0;                        // [R11]
    end else if (sel < SEL_W2_BASE) begin
      state_next.drive = word_one[w1_idx] ^ invert;   // [R10] [R12] [R14]
    end else if (sel < SEL_W2_END) begin
      state_next.drive = word_two[w2_idx] ^ invert;   // [R13] [R14]
    end else begin
      state_next.drive = 1'b0;
    end
  end

  // Registered so a select change never glitches the relay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign drive = state_reg.drive;

endmodule

/* File: hdl/terminal_io_routing_failsafe.sv */
// Terminal inputs, paired safety input and routed binary outputs
`timescale 1ns/100ps
// What this block does
// R1 - Each terminal input has a configurable debounce
// R2 - Analog channels may serve as binary inputs
// R3 - Inputs five and six form one safety input
// R4 - Software picks the fail-safe interface assignment
// R5 - Torque off needs the function enabled
// R6 - Safety input high idle, low demands
// R7 - Relay keeps both channels at equal level
// R8 - Channel disagreement raises a fault
// R9 - Cross shorts and supply shorts go undetected
// R10 - Each output follows a selected status bit
// R11 - Select zero holds the output off
// R12 - Word one bits are selectable sources
// R13 - Word two bits zero to fifteen selectable
// R14 - Per-output inversion of the selected source
// R15 - Filtered inputs readable as status bits
// R16 - Discrepancy forces torque off until acknowledged
module terminal_io_routing_failsafe
  import term_io_pkg::*;
#(
  parameter int NUM_DI      = 6,
  parameter int NUM_AI      = 2,
  parameter int NUM_DO      = 3,
  parameter int TICK_CYCLES = DEB_TICK_CYC,
  parameter int DISC_CYCLES = DISC_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rdata,
  // Terminal pins
  input  wire logic [NUM_DI-1:0] term_in_pin,
  input  wire logic [NUM_AI-1:0] ai_level_pin,
  output logic      [NUM_DO-1:0] term_out_pin,
  // Drive status from the control core
  input  wire logic [15:0]       drive_status_word_one,
  input  wire logic [15:0]       drive_status_word_two,
  // To the control core
  output logic [NUM_DI+NUM_AI-1:0] binary_in,
  output logic                     safe_torque_off,
  output logic                     discrepancy_fault,
  output logic                     irq
);

  localparam int NUM_IN = NUM_DI + NUM_AI;
  localparam int CH0    = 4;
  localparam int CH1    = 5;

  // Register set, in address order:
  //   control            torque off enable, analog-as-input enables
  //   interface          pairing of the safety channels
  //   debounce           filter limit in ticks
  //   output selects     one per output, zero holds it off
  //   invert mask        one bit per output
  //   input status       filtered levels, paired channels read zero
  //   safety status      demand, fault, both channel levels
  //   interrupt status   sticky events, write one to clear
  //   interrupt mask     same layout as the status
  //   command            fault acknowledge, write only
  //   status words       two words from the control core, read only

  typedef struct packed {
    logic [NUM_IN-1:0]      sync1;
    logic [NUM_IN-1:0]      sync2;
    logic [15:0]            tick_cnt;
    logic                   tick;
    logic                   sto_en;
    logic [NUM_AI-1:0]      ai_en;
    logic [3:0]             iface;
    logic [7:0]             deb_time;
    logic [NUM_DO-1:0][5:0] sel;
    logic [NUM_DO-1:0]      inv;
    logic [15:0]            disc_cnt;
    logic                   fault;
    logic                   sto_act;
    logic [NUM_IN-1:0]      prev_lvl;
    logic [2:0]             irq_st;
    logic [2:0]             irq_mask;
    logic [DATA_W-1:0]      rdata;
  } io_state_t;

  io_state_t         state_reg;
  io_state_t         state_next;
  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] avail;
  logic              paired;
  logic              disagree;
  logic [2:0]        events;
  logic [DATA_W-1:0] rd_val;
  logic              ack_req;
  logic              fault_hit;
  logic              chan_low;
  logic [2:0]        irq_clr;
  logic [2:0]        irq_pend;
  logic              wr_ctrl;
  logic              wr_iface;
  logic              wr_deb;
  logic              wr_sel;
  logic              wr_inv;
  logic              wr_irq_st;
  logic              wr_mask;

  ////////////////////////////////////////////////////////////////////////
  // Address helpers, shared by the read and write decoders

  // Address falls on one of the output select registers
  function automatic logic sel_hit(input logic [ADDR_W-1:0] a);
    return (a >= SEL0_OFS) && (a < SEL0_OFS + 4'(NUM_DO));
  endfunction

  // Output number that a select register address belongs to
  function automatic logic [1:0] sel_idx(input logic [ADDR_W-1:0] a);
    return 2'(a - SEL0_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Debounce filters, one per terminal and analog channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
      input_filter #(
        .CNT_W (8)
      ) u_filt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (state_reg.tick),
        .limit   (state_reg.deb_time),
        .raw     (state_reg.sync2[gi]),
        .level   (lvl[gi])                     // [R1]
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output routing, one per binary output
  generate
    for (gi = 0; gi < NUM_DO; gi++) begin : g_out
      output_route u_route (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .word_one (drive_status_word_one),
        .word_two (drive_status_word_two),
        .sel      (state_reg.sel[gi]),
        .invert   (state_reg.inv[gi]),
        .drive    (term_out_pin[gi])           // [R10] [R14]
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Input availability and safety pairing
  // Paired channels are withheld from the ordinary input vector
  assign paired = (state_reg.iface == IFACE_FAILSAFE);   // [R3] [R4]

  always_comb begin
    avail = '1;
    for (int i = 0; i < NUM_AI; i++) begin
      avail[NUM_DI+i] = state_reg.ai_en[i];               // [R2]
    end
    if (paired) begin
      avail[CH0] = 1'b0;                                  // [R3]
      avail[CH1] = 1'b0;
    end
  end

  // Cross shorts keep the channels equal, so they cannot show here [R9]
  assign disagree = lvl[CH0] ^ lvl[CH1];                  // [R8] [R7]

  // Tolerance used up with the channels still apart
  assign fault_hit = paired && disagree &&
                     (state_reg.disc_cnt >= 16'(DISC_CYCLES - 1));   // [R8]

  // Either channel low is a demand on its own
  assign chan_low = !lvl[CH0] || !lvl[CH1];               // [R6]

  ////////////////////////////////////////////////////////////////////////
  // Write decode; read-only and unmapped addresses fall through
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_iface  = 1'b0;
    wr_deb    = 1'b0;
    wr_sel    = 1'b0;
    wr_inv    = 1'b0;
    wr_irq_st = 1'b0;
    wr_mask   = 1'b0;
    if (wr_stb) begin
      if (addr == CTRL_OFS) begin
        wr_ctrl = 1'b1;
      end else if (addr == IFACE_OFS) begin
        wr_iface = 1'b1;
      end else if (addr == DEB_TIME_OFS) begin
        wr_deb = 1'b1;
      end else if (sel_hit(addr)) begin
        wr_sel = 1'b1;
      end else if (addr == INV_OFS) begin
        wr_inv = 1'b1;
      end else if (addr == IRQ_STATUS_OFS) begin
        wr_irq_st = 1'b1;
      end else if (addr == IRQ_MASK_OFS) begin
        wr_mask = 1'b1;
      end
    end
  end

  // Requests acted on by the next-state logic
  assign ack_req = wr_stb && (addr == CMD_OFS) && wdata[CMD_ACK_BIT];   // [R16]
  assign irq_clr = wr_irq_st ? wdata[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    rd_val = '0;
    if (addr == CTRL_OFS) begin
      rd_val[CTRL_STO_EN_BIT] = state_reg.sto_en;
      rd_val[CTRL_AI_EN_LSB +: NUM_AI] = state_reg.ai_en;
    end else if (addr == IFACE_OFS) begin
      rd_val[3:0] = state_reg.iface;
    end else if (addr == DEB_TIME_OFS) begin
      rd_val[7:0] = state_reg.deb_time;
    end else if (sel_hit(addr)) begin
      rd_val[5:0] = state_reg.sel[sel_idx(addr)];
    end else if (addr == INV_OFS) begin
      rd_val[NUM_DO-1:0] = state_reg.inv;
    end else if (addr == IN_STATUS_OFS) begin
      rd_val[NUM_IN-1:0] = lvl & avail;                   // [R15]
    end else if (addr == SAFE_STATUS_OFS) begin
      rd_val[SAFE_ACTIVE_BIT] = state_reg.sto_act;
      rd_val[SAFE_FAULT_BIT]  = state_reg.fault;
      rd_val[SAFE_CH0_BIT]    = lvl[CH0];
      rd_val[SAFE_CH1_BIT]    = lvl[CH1];
    end else if (addr == IRQ_STATUS_OFS) begin
      rd_val[2:0] = state_reg.irq_st;
    end else if (addr == IRQ_MASK_OFS) begin
      rd_val[2:0] = state_reg.irq_mask;
    end else if (addr == WORD_ONE_OFS) begin
      rd_val = drive_status_word_one;
    end else if (addr == WORD_TWO_OFS) begin
      rd_val = drive_status_word_two;
    end else begin
      rd_val = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;

    // Two-stage synchronisers for every pin
    state_next.sync1 = {ai_level_pin, term_in_pin};
    state_next.sync2 = state_reg.sync1;

    // Debounce time base
    if (state_reg.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
      state_next.tick_cnt = '0;
      state_next.tick     = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
      state_next.tick     = 1'b0;
    end

    // Discrepancy timer: brief skew between contacts is tolerated
    if (!disagree) begin
      state_next.disc_cnt = '0;
    end else if (state_reg.disc_cnt < 16'(DISC_CYCLES - 1)) begin
      state_next.disc_cnt = state_reg.disc_cnt + 16'h0001;
    end

    // Fault latches; acknowledge only clears once channels agree
    if (ack_req && !disagree) begin
      state_next.fault = 1'b0;                            // [R16]
    end
    if (fault_hit) begin
      state_next.fault = 1'b1;                            // [R8]
    end

    // Torque off: low on either channel or a held fault
    state_next.sto_act = state_reg.sto_en && paired &&    // [R5] [R4]
                         (chan_low ||                     // [R6]
                          state_next.fault);              // [R16]

    state_next.prev_lvl = lvl;
    state_next.rdata    = rd_stb ? rd_val : '0;

    // Register writes, one decoded enable each
    if (wr_ctrl) begin
      state_next.sto_en = wdata[CTRL_STO_EN_BIT];
      state_next.ai_en  = wdata[CTRL_AI_EN_LSB +: NUM_AI];
    end
    if (wr_iface) begin
      state_next.iface = wdata[3:0];
    end
    if (wr_deb) begin
      state_next.deb_time = wdata[7:0];
    end
    if (wr_sel) begin
      state_next.sel[sel_idx(addr)] = wdata[5:0];
    end
    if (wr_inv) begin
      state_next.inv = wdata[NUM_DO-1:0];
    end
    if (wr_mask) begin
      state_next.irq_mask = wdata[2:0];
    end

    // Interrupt events, formed here so no loop runs through a separate net
    events[IRQ_FAULT_BIT]  = state_next.fault & ~state_reg.fault;
    events[IRQ_STO_BIT]    = state_next.sto_act & ~state_reg.sto_act;
    events[IRQ_CHANGE_BIT] = |((lvl ^ state_reg.prev_lvl) & avail);

    // Events set after the clear so a coinciding event survives
    state_next.irq_st = (state_reg.irq_st & ~irq_clr) | events;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg          <= '0;
      state_reg.iface    <= IFACE_RST;
      state_reg.deb_time <= DEB_TIME_RST;
      state_reg.sel      <= {NUM_DO{SEL_RST}};
      state_reg.irq_mask <= IRQ_MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata             = state_reg.rdata;
  assign binary_in         = lvl & avail;
  assign safe_torque_off   = state_reg.sto_act;
  assign discrepancy_fault = state_reg.fault;
  assign irq_pend          = state_reg.irq_st & state_reg.irq_mask;
  assign irq               = |irq_pend;

endmodule

/* File: verif/term_io_properties.sv */
// Port-level checks for the terminal routing block
`timescale 1ns/100ps
module term_io_properties
  import term_io_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  // Pins and status
  input wire logic [5:0]  term_in_pin,
  input wire logic [2:0]  term_out_pin,
  input wire logic [15:0] drive_status_word_one,
  input wire logic [15:0] drive_status_word_two,
  input wire logic        safe_torque_off,
  input wire logic        discrepancy_fault,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Shadow of routing and mask, so no peeking inside is needed
  logic [17:0] sel_reg;
  logic [2:0]  inv_reg;
  logic [2:0]  mask_reg;
  logic [2:0]  exp_out;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_reg  <= '0;
      inv_reg  <= '0;
      mask_reg <= '0;
    end else if (wr_stb) begin
      for (int k = 0; k < 3; k++)
        if (addr == SEL0_OFS + 4'(k)) sel_reg[6*k +: 6] <= wdata[5:0];
      if (addr == INV_OFS) inv_reg <= wdata[2:0];
      if (addr == IRQ_MASK_OFS) mask_reg <= wdata[2:0];
    end
  end
  // Codes beyond word two give off, so inversion never lights them
  always_comb begin
    logic [5:0] s;
    s = '0;
    for (int k = 0; k < 3; k++) begin
      s = sel_reg[6*k +: 6];
      if (s >= SEL_W1_BASE && s < SEL_W2_BASE)
        exp_out[k] = drive_status_word_one[4'(s - SEL_W1_BASE)] ^ inv_reg[k];
      else if (s >= SEL_W2_BASE && s < SEL_W2_END)
        exp_out[k] = drive_status_word_two[4'(s - SEL_W2_BASE)] ^ inv_reg[k];
      else
        exp_out[k] = 1'b0;
    end
  end
  sequence fault_raised;
    $rose(discrepancy_fault) && mask_reg[IRQ_FAULT_BIT];
  endsequence
  ////////////////////////////////////////////////////////////
  chk_rd_quiet: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data outside its slot");
  chk_word_readback: assert property ($past(rd_stb) && $past(addr) == WORD_ONE_OFS
    |-> rdata == $past(drive_status_word_one) || rdata == $past(drive_status_word_one, 2))
    else $error("status word readback wrong");
  chk_out_route: assert property (term_out_pin == $past(exp_out))
    else $error("output not the selected source");
  chk_fault_holds: assert property ($past(discrepancy_fault)
    && !($past(wr_stb) && $past(addr) == CMD_OFS) |-> discrepancy_fault)
    else $error("fault cleared without acknowledge");
  chk_fault_cause: assert property ($rose(discrepancy_fault)
    |-> $past(term_in_pin[4], 4) != $past(term_in_pin[5], 4))
    else $error("fault without channel disagreement");
  chk_sto_holds: assert property ($past(safe_torque_off) && $past(discrepancy_fault)
    && !$past(wr_stb) |-> safe_torque_off)
    else $error("torque off dropped while fault latched");
  chk_irq_fault: assert property (fault_raised |-> ##[0:2] irq)
    else $error("unmasked fault gave no interrupt");
  chk_irq_masked: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
    else $error("interrupt while fully masked");
endmodule

bind terminal_io_routing_failsafe term_io_properties u_term_io_properties (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .term_in_pin(term_in_pin),
  .term_out_pin(term_out_pin), .drive_status_word_one(drive_status_word_one),
  .drive_status_word_two(drive_status_word_two), .safe_torque_off(safe_torque_off),
  .discrepancy_fault(discrepancy_fault), .irq(irq)
);

/* File: verif/safety_field_model.sv */
// Field side: safety relay, plain switches and thresholded analog sources
`timescale 1ns/100ps
module safety_field_model (
  // Clock
  input  wire logic       clk,
  // Scenario commands
  input  wire logic       relay_closed,
  input  wire logic       cable_break,
  input  wire logic [3:0] switch_set,
  input  wire logic [1:0] analog_set,
  // Terminal side
  output logic      [5:0] term_in_pin,
  output logic      [1:0] ai_level_pin
);
  initial term_in_pin = 6'h00;
  initial ai_level_pin = 2'h0;
  // One contact feeds both wires; a broken wire reads low, shorts never made
  always @(posedge clk) begin
    term_in_pin[3:0] <= switch_set;
    term_in_pin[4]   <= relay_closed;
    term_in_pin[5]   <= relay_closed & ~cable_break;
    ai_level_pin     <= analog_set;
  end
endmodule

/* File: verif/terminal_io_routing_failsafe_bench.sv */
// Self-checking bench for the terminal routing block
`timescale 1ns/100ps
module terminal_io_routing_failsafe_bench;
  import term_io_pkg::*;
  typedef struct packed {
    logic [5:0] sel;
    logic       inv;
    logic       out;
  } route_row_t;
  // Words hold fault, limit alarm, braking, above minimum, at setpoint
  localparam logic [15:0] WORD1 = 16'h0808;
  localparam logic [15:0] WORD2 = 16'h0045;
  localparam route_row_t ROWS [10] = '{
    '{6'h00, 1'b1, 1'b0}, '{6'h04, 1'b0, 1'b1}, '{6'h0c, 1'b0, 1'b1},
    '{6'h02, 1'b0, 1'b0}, '{6'h11, 1'b0, 1'b1}, '{6'h13, 1'b0, 1'b1},
    '{6'h17, 1'b0, 1'b1}, '{6'h04, 1'b1, 1'b0}, '{6'h20, 1'b1, 1'b1},
    '{6'h21, 1'b1, 1'b0}};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [15:0] rdata;
  logic [5:0]  term_in_pin;
  logic [1:0]  ai_level_pin;
  logic [2:0]  term_out_pin;
  logic [7:0]  binary_in;
  logic        safe_torque_off;
  logic        discrepancy_fault;
  logic        irq;
  logic        relay_closed = 1'b0;
  logic        cable_break = 1'b0;
  logic [3:0]  switch_set = 4'h0;
  logic [1:0]  analog_set = 2'h0;
  int          mismatches = 0;
  int          comparisons = 0;

  always #25 clk = ~clk;

  // Short tick and tolerance keep the run brief
  terminal_io_routing_failsafe #(.TICK_CYCLES(4), .DISC_CYCLES(8)) u_terminal_io_routing_failsafe (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .term_in_pin(term_in_pin),
    .ai_level_pin(ai_level_pin), .term_out_pin(term_out_pin),
    .drive_status_word_one(WORD1), .drive_status_word_two(WORD2),
    .binary_in(binary_in), .safe_torque_off(safe_torque_off),
    .discrepancy_fault(discrepancy_fault), .irq(irq));
  safety_field_model u_safety_field_model (
    .clk(clk), .relay_closed(relay_closed), .cable_break(cable_break),
    .switch_set(switch_set), .analog_set(analog_set),
    .term_in_pin(term_in_pin), .ai_level_pin(ai_level_pin));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Whole sequence needs well under 1000 cycles
  initial begin
    #(20000 * 50);
    mismatches++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    int k;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      k = i % 3;
      wr(SEL0_OFS + 4'(k), 16'(ROWS[i].sel));
      wr(INV_OFS, 16'(ROWS[i].inv) << k);
      wait_cyc(2);
      check(16'(term_out_pin[k]), 16'(ROWS[i].out));
    end
    // Reset value, unmapped place, read-only word
    rd(IFACE_OFS, 16'(IFACE_RST));
    rd(4'hf, 16'h0000);
    wr(WORD_ONE_OFS, 16'h1234);
    rd(WORD_ONE_OFS, WORD1);
    rd(WORD_TWO_OFS, WORD2);
    // Plain and analog inputs with debounce off
    wr(CTRL_OFS, 16'h0006);
    switch_set <= 4'ha;
    analog_set <= 2'b10;
    wait_cyc(8);
    check(16'(binary_in), 16'h008a);
    rd(IN_STATUS_OFS, 16'h008a);
    wr(CTRL_OFS, 16'h0000);
    wait_cyc(2);
    check(16'(binary_in), 16'h000a);
    // Debounce of 3 ticks hides a short wait
    wr(DEB_TIME_OFS, 16'h0003);
    switch_set <= 4'hb;
    wait_cyc(6);
    check(16'(binary_in[0]), 16'h0000);
    wait_cyc(40);
    check(16'(binary_in[0]), 16'h0001);
    wr(DEB_TIME_OFS, 16'h0000);
    // Paired safety input
    relay_closed <= 1'b1;
    wr(IFACE_OFS, 16'(IFACE_FAILSAFE));
    wr(IRQ_MASK_OFS, 16'h0001);
    wr(CTRL_OFS, 16'h0001);
    wait_cyc(6);
    check(16'(safe_torque_off), 16'h0000);
    rd(IN_STATUS_OFS, 16'h000b);
    rd(SAFE_STATUS_OFS, 16'h000c);
    relay_closed <= 1'b0;
    wait_cyc(14);
    check(16'(safe_torque_off), 16'h0001);
    check(16'(discrepancy_fault), 16'h0000);
    wr(CTRL_OFS, 16'h0000);
    wait_cyc(3);
    check(16'(safe_torque_off), 16'h0000);
    wr(CTRL_OFS, 16'h0001);
    relay_closed <= 1'b1;
    wait_cyc(6);
    // Broken wire: fault, then acknowledge refused until channels agree
    cable_break <= 1'b1;
    wait_cyc(20);
    check(16'(discrepancy_fault), 16'h0001);
    check(16'(irq), 16'h0001);
    wr(CMD_OFS, 16'h0001);
    cable_break <= 1'b0;
    wait_cyc(6);
    check(16'(discrepancy_fault), 16'h0001);
    check(16'(safe_torque_off), 16'h0001);
    rd(IRQ_STATUS_OFS, 16'h0007);
    wr(IRQ_STATUS_OFS, 16'h0007);
    wait_cyc(2);
    check(16'(irq), 16'h0000);
    rd(IRQ_STATUS_OFS, 16'h0000);
    wr(CMD_OFS, 16'h0001);
    wait_cyc(3);
    check(16'(safe_torque_off), 16'h0000);
    rd(SAFE_STATUS_OFS, 16'h000c);
    end_sim();
  end
endmodule
